// File: jsp_jtag_select.sv
/*
  Priority selector that routes one of three test-access sources to the
  target test port, plus a target clock activity monitor.
  Assumes presence pins are asynchronous, link_tck_i is the test clock as
  seen at the target, and the test signals pass through combinationally.
*/
`timescale 1ns/1ps

`include "jsp_cfg.svh"

module jsp_jtag_select #(
  parameter int IDLE_CYC = `JSP_IDLE_CYC
) (
  // clocks and reset
  input wire logic sys_clk_i,
  input wire logic link_tck_i,
  input wire logic rst_b_i,
  // presence indications
  input wire logic cable_present_detect_i,
  input wire logic usb_bus_power_i,
  // external cable connector
  input wire logic ext_tck_i,
  input wire logic ext_tms_i,
  input wire logic ext_tdi_i,
  output logic ext_tdo_o,
  // usb bridge first data channel
  input wire logic usb_tck_i,
  input wire logic usb_tms_i,
  input wire logic usb_tdi_i,
  output logic usb_tdo_o,
  // fabric self-access pins
  input wire logic fab_tck_i,
  input wire logic fab_tms_i,
  input wire logic fab_tdi_i,
  output logic fab_tdo_o,
  // target test port
  output logic tgt_tck_o,
  output logic tgt_tms_o,
  output logic tgt_tdi_o,
  input wire logic tgt_tdo_i,
  // status
  output logic [1:0] active_src_o,
  output logic link_active_o
);

  localparam logic [2:0] GUARD_LOAD = 3'(`JSP_GUARD_CYC - 1);
  localparam logic [15:0] IDLE_LOAD = 16'(IDLE_CYC);
  localparam int GUARD_MAX = `JSP_GUARD_CYC + 2;

  jsp_pkg::jsp_src_t state_q;
  jsp_pkg::jsp_src_t state_d;
  jsp_pkg::jsp_src_t want_w;
  logic [2:0] guard_q;
  logic [2:0] guard_d;
  logic act_tgl_q;
  logic [15:0] idle_q;
  logic [15:0] idle_d;

  wire cable_on_w;
  wire usb_on_w;
  wire sel_ext_w;
  wire sel_usb_w;
  wire sel_fab_w;
  wire none_w;

  jsp_sync_if #(.W(`JSP_DET_WIDTH)) det_if ();
  jsp_sync_if #(.W(1)) act_if ();

  // presence pins into the system domain
  jsp_sync #(
    .W(`JSP_DET_WIDTH)
  ) u_det_sync (
    .clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .async_i({usb_bus_power_i, cable_present_detect_i}),
    .sync_if(det_if)
  );

  // target clock activity toggle into the system domain
  jsp_sync #(
    .W(1)
  ) u_act_sync (
    .clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .async_i(act_tgl_q),
    .sync_if(act_if)
  );

  assign cable_on_w = det_if.level[`JSP_DET_CABLE_BIT];
  assign usb_on_w = det_if.level[`JSP_DET_USB_BIT];

  // fixed priority decode
  assign want_w = cable_on_w ? jsp_pkg::JSP_SRC_EXT :
                  usb_on_w ? jsp_pkg::JSP_SRC_USB :
                  jsp_pkg::JSP_SRC_FAB;

  // break-before-make source fsm
  always_comb
  begin
    state_d = state_q;
    guard_d = guard_q;
    case (state_q)
      jsp_pkg::JSP_SRC_NONE:
      begin
        if (guard_q == 3'h0)
        begin
          state_d = want_w;
        end
        else
        begin
          guard_d = guard_q - 3'h1;
        end
      end
      jsp_pkg::JSP_SRC_FAB,
      jsp_pkg::JSP_SRC_USB,
      jsp_pkg::JSP_SRC_EXT:
      begin
        if (want_w != state_q)
        begin
          state_d = jsp_pkg::JSP_SRC_NONE;
          guard_d = GUARD_LOAD;
        end
      end
      default:
      begin
        state_d = jsp_pkg::JSP_SRC_NONE;
        guard_d = GUARD_LOAD;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_q <= jsp_pkg::JSP_SRC_NONE;
      guard_q <= GUARD_LOAD;
    end
    else
    begin
      state_q <= state_d;
      guard_q <= guard_d;
    end
  end

  assign sel_ext_w = (state_q == jsp_pkg::JSP_SRC_EXT);
  assign sel_usb_w = (state_q == jsp_pkg::JSP_SRC_USB);
  assign sel_fab_w = (state_q == jsp_pkg::JSP_SRC_FAB);
  assign none_w = (state_q == jsp_pkg::JSP_SRC_NONE);

  // routing to the target, one source at a time
  assign tgt_tck_o = sel_ext_w ? ext_tck_i :
                     sel_usb_w ? usb_tck_i :
                     sel_fab_w ? fab_tck_i :
                     `JSP_IDLE_TCK;
  assign tgt_tms_o = sel_ext_w ? ext_tms_i :
                     sel_usb_w ? usb_tms_i :
                     sel_fab_w ? fab_tms_i :
                     `JSP_IDLE_TMS;
  assign tgt_tdi_o = sel_ext_w ? ext_tdi_i :
                     sel_usb_w ? usb_tdi_i :
                     sel_fab_w ? fab_tdi_i :
                     `JSP_IDLE_TDI;

  // tdo return, idle high when unrouted
  assign ext_tdo_o = sel_ext_w ? tgt_tdo_i : `JSP_IDLE_TDO;
  assign usb_tdo_o = sel_usb_w ? tgt_tdo_i : `JSP_IDLE_TDO;
  assign fab_tdo_o = sel_fab_w ? tgt_tdo_i : `JSP_IDLE_TDO;

  assign active_src_o = state_q;

  // link domain: one toggle per rising target clock edge
  always_ff @(posedge link_tck_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      act_tgl_q <= 1'h0;
    end
    else
    begin
      act_tgl_q <= ~act_tgl_q;
    end
  end

  // activity hold counter
  assign idle_d = act_if.changed ? IDLE_LOAD :
                  (idle_q != 16'h0000) ? idle_q - 16'h0001 : idle_q;

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      idle_q <= 16'h0000;
    end
    else
    begin
      idle_q <= idle_d;
    end
  end

  assign link_active_o = (idle_q != 16'h0000);

  // checks

  property p_ext_route;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    sel_ext_w |-> (tgt_tck_o == ext_tck_i) && (tgt_tms_o == ext_tms_i) &&
      (tgt_tdi_o == ext_tdi_i) && (ext_tdo_o == tgt_tdo_i);
  endproperty
  a_ext_route: assert property (p_ext_route)
    else $error("external source not routed while selected");

  property p_ext_exclusive;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    sel_ext_w |-> (usb_tdo_o == 1'h1) && (fab_tdo_o == 1'h1) && $past(cable_on_w);
  endproperty
  a_ext_exclusive: assert property (p_ext_exclusive)
    else $error("other source reachable while external selected");

  property p_cable_wins;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (cable_on_w && !sel_ext_w) |-> ##[1:GUARD_MAX] (sel_ext_w || !cable_on_w);
  endproperty
  a_cable_wins: assert property (p_cable_wins)
    else $error("cable present but external not selected in time");

  property p_usb_fallback;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (!cable_on_w && usb_on_w && !sel_usb_w) |->
      ##[1:GUARD_MAX] (sel_usb_w || cable_on_w || !usb_on_w);
  endproperty
  a_usb_fallback: assert property (p_usb_fallback)
    else $error("usb not selected after cable removal");

  property p_usb_cause;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    sel_usb_w |-> $past(usb_on_w) && !$past(cable_on_w);
  endproperty
  a_usb_cause: assert property (p_usb_cause)
    else $error("usb selected without usb power or with cable");

  property p_fab_cause;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    sel_fab_w |-> !$past(usb_on_w) && !$past(cable_on_w);
  endproperty
  a_fab_cause: assert property (p_fab_cause)
    else $error("fabric selected while another source present");

  property p_idle_tdo;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    none_w |-> (ext_tdo_o && usb_tdo_o && fab_tdo_o) && (tgt_tms_o == 1'h1) &&
      (tgt_tck_o == 1'h0);
  endproperty
  a_idle_tdo: assert property (p_idle_tdo)
    else $error("unrouted ports not idle during gap");

  property p_reeval;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    (!none_w && (want_w != state_q)) |=> none_w [*4] ##1 (state_q == $past(want_w));
  endproperty
  a_reeval: assert property (p_reeval)
    else $error("presence change not followed by gap and reselection");

  property p_gap_before;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    ($changed(state_q) && !none_w) |-> $past(none_w, `JSP_GUARD_CYC);
  endproperty
  a_gap_before: assert property (p_gap_before)
    else $error("source switched without full gap");

  property p_usb_route;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    sel_usb_w |-> (tgt_tck_o == usb_tck_i) && (tgt_tms_o == usb_tms_i) &&
      (tgt_tdi_o == usb_tdi_i) && (usb_tdo_o == tgt_tdo_i) && ext_tdo_o && fab_tdo_o;
  endproperty
  a_usb_route: assert property (p_usb_route)
    else $error("usb source not routed alone while selected");

  property p_fab_route;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    sel_fab_w |-> (tgt_tck_o == fab_tck_i) && (tgt_tms_o == fab_tms_i) &&
      (tgt_tdi_o == fab_tdi_i) && (fab_tdo_o == tgt_tdo_i) && ext_tdo_o && usb_tdo_o;
  endproperty
  a_fab_route: assert property (p_fab_route)
    else $error("fabric source not routed alone while selected");

  property p_gap_bounded;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    $rose(none_w) |-> ##[1:GUARD_MAX] !none_w;
  endproperty
  a_gap_bounded: assert property (p_gap_bounded)
    else $error("source gap not ended in time");

  c_ext: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i) $rose(sel_ext_w));
  c_usb: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i) $rose(sel_usb_w));
  c_fab: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i) $rose(sel_fab_w));
  c_ext_to_usb: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    sel_ext_w ##1 none_w [*4] ##1 sel_usb_w);
  c_link: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i) $rose(link_active_o));

endmodule : jsp_jtag_select

// File: jsp_cfg.svh
/*
  Constants for the JTAG source priority selector: field positions,
  idle levels and timing counts.
  Assumes a 200 MHz system clock; included by its bare name.
*/
`ifndef JSP_CFG_SVH
`define JSP_CFG_SVH

// system clock period in picoseconds
`define JSP_CLK_PERIOD_PS 5000

// break-before-make gap, least time
`define JSP_GUARD_NS 20
`define JSP_GUARD_CYC ((`JSP_GUARD_NS * 1000 + `JSP_CLK_PERIOD_PS - 1) / `JSP_CLK_PERIOD_PS)

// link activity hold time, longest time
`define JSP_IDLE_NS 2000
`define JSP_IDLE_CYC ((`JSP_IDLE_NS * 1000) / `JSP_CLK_PERIOD_PS)

// presence vector bit positions
`define JSP_DET_CABLE_BIT 0
`define JSP_DET_USB_BIT 1
`define JSP_DET_WIDTH 2

// synchroniser depth
`define JSP_SYNC_STAGES 3

// idle levels seen by an unrouted port
`define JSP_IDLE_TCK 1'h0
`define JSP_IDLE_TMS 1'h1
`define JSP_IDLE_TDI 1'h1
`define JSP_IDLE_TDO 1'h1

`endif

// File: jsp_pkg.sv
/*
  Types for the JTAG source priority selector.
  Assumes nothing of its surroundings.
*/
package jsp_pkg;

  // gray order along none -> fabric -> usb -> external
  typedef enum logic [1:0] {
    JSP_SRC_NONE = 2'h0,
    JSP_SRC_FAB = 2'h1,
    JSP_SRC_USB = 2'h3,
    JSP_SRC_EXT = 2'h2
  } jsp_src_t;

endpackage : jsp_pkg

// File: jsp_sync_if.sv
/*
  Carrier for synchronised levels and their change pulse.
  Assumes the producer and the consumer share one clock.
*/
`timescale 1ns/1ps

interface jsp_sync_if #(
  parameter int W = 1
);
  logic [W-1:0] level;
  logic changed;

  modport src (
    output level,
    output changed
  );

  modport dst (
    input level,
    input changed
  );
endinterface : jsp_sync_if

// File: jsp_sync.sv
/*
  Three-stage synchroniser with agreement filter.
  Assumes asynchronous inputs and an active-low asynchronous reset.
*/
`timescale 1ns/1ps

module jsp_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // asynchronous input
  input wire logic [W-1:0] async_i,
  // synchronised result
  jsp_sync_if.src sync_if
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] stable_q;
  logic [W-1:0] stable_d;
  logic changed_q;
  wire [W-1:0] agree_w;

  // a change counts once stages two and three agree
  assign agree_w = ~(s2_q ^ s3_q);
  assign stable_d = (s3_q & agree_w) | (stable_q & ~agree_w);

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      stable_q <= '0;
      changed_q <= 1'h0;
    end
    else
    begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      stable_q <= stable_d;
      changed_q <= |(stable_d ^ stable_q);
    end
  end

  assign sync_if.level = stable_q;
  assign sync_if.changed = changed_q;

endmodule : jsp_sync

// File: jsp_tgt_model.sv
/*
  target test port model: shifts tdi into tdo on each tck rise.
  assumes tck stands still outside frames.
*/
`timescale 1ns/1ps

module jsp_tgt_model (
  // test port
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  output logic tdo_o
);
  logic cap_q;

  initial cap_q = 1'h0;
  always @(posedge tck_i) cap_q <= tdi_i;
  assign tdo_o = cap_q;
endmodule : jsp_tgt_model

// File: jsp_jtag_select_tb_top.sv
/*
  self-checking bench for the jtag source priority selector.
  assumes the target model on the routed test port.
*/
`timescale 1ns/1ps

module jsp_jtag_select_tb_top;
  logic sys_clk_i, rst_b_i, cab, usb, tck, tms, tdi, tdo, lact;
  logic ext_tdo, usb_tdo, fab_tdo;
  logic [2:0] ext_s, usb_s, fab_s;
  logic [1:0] src;
  int err_count, n_checks, cyc;

  jsp_jtag_select #(.IDLE_CYC(20)) i_dut (
    .sys_clk_i(sys_clk_i), .link_tck_i(tck), .rst_b_i(rst_b_i),
    .cable_present_detect_i(cab), .usb_bus_power_i(usb),
    .ext_tck_i(ext_s[2]), .ext_tms_i(ext_s[1]), .ext_tdi_i(ext_s[0]), .ext_tdo_o(ext_tdo),
    .usb_tck_i(usb_s[2]), .usb_tms_i(usb_s[1]), .usb_tdi_i(usb_s[0]), .usb_tdo_o(usb_tdo),
    .fab_tck_i(fab_s[2]), .fab_tms_i(fab_s[1]), .fab_tdi_i(fab_s[0]), .fab_tdo_o(fab_tdo),
    .tgt_tck_o(tck), .tgt_tms_o(tms), .tgt_tdi_o(tdi), .tgt_tdo_i(tdo),
    .active_src_o(src), .link_active_o(lact));

  jsp_tgt_model i_tgt (.tck_i(tck), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo));

  initial
  begin
    sys_clk_i = 1'h0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  task automatic end_sim;
    if (err_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim

  task automatic check(input string name, input logic [3:0] seen, input logic [3:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // gap with idle routing, then the wanted source
  task automatic to_src(input logic [1:0] exp);
    int n;
    n = 0;
    @(negedge sys_clk_i);
    ext_s = 3'h0;
    usb_s = 3'h0;
    fab_s = 3'h0;
    while (src !== 2'h0 && n < 20)
    begin
      @(negedge sys_clk_i);
      n++;
    end
    check("gap_src", {2'h0, src}, 4'h0);
    check("gap_tgt", {1'h0, tck, tms, tdi}, 4'h3);
    check("gap_tdo", {1'h0, ext_tdo, usb_tdo, fab_tdo}, 4'h7);
    n = 0;
    while (src !== exp && n < 20)
    begin
      @(negedge sys_clk_i);
      n++;
    end
    check("active_src", {2'h0, src}, {2'h0, exp});
    check("sel_tgt", {1'h0, tck, tms, tdi}, 4'h0);
    @(negedge sys_clk_i);
    ext_s = 3'h3;
    usb_s = 3'h3;
    fab_s = 3'h3;
  endtask : to_src

  // distinct levels on all sources, only the selected one reaches the target
  task automatic route(input logic [1:0] s);
    logic [2:0] p, e;
    for (int i = 0; i < 2; i++)
    begin
      p = (i == 0) ? 3'h1 : 3'h6;
      @(negedge sys_clk_i);
      ext_s[1:0] = p[1:0];
      usb_s[1:0] = p[1:0] ^ 2'h3;
      fab_s[1:0] = p[1:0] ^ 2'h1;
      #1;
      ext_s = p;
      usb_s = p ^ 3'h3;
      fab_s = p ^ 3'h5;
      #1;
      e = (s == jsp_pkg::JSP_SRC_EXT) ? ext_s : (s == jsp_pkg::JSP_SRC_USB) ? usb_s : fab_s;
      check("tgt", {1'h0, tck, tms, tdi}, {1'h0, e});
      check("ext_tdo", {3'h0, ext_tdo}, {3'h0, (s == 2'h2) ? tdo : 1'h1});
      check("usb_tdo", {3'h0, usb_tdo}, {3'h0, (s == 2'h3) ? tdo : 1'h1});
      check("fab_tdo", {3'h0, fab_tdo}, {3'h0, (s == 2'h1) ? tdo : 1'h1});
    end
    @(negedge sys_clk_i);
    ext_s = 3'h3;
    usb_s = 3'h3;
    fab_s = 3'h3;
  endtask : route

  // usb channel clocks a frame at 48 ns, then stops
  task automatic link_frame;
    @(negedge sys_clk_i);
    for (int i = 0; i < 8; i++)
    begin
      usb_s = {2'h1, i[0]};
      #24;
      usb_s[2] = 1'h1;
      #1;
      check("usb_shift", {3'h0, usb_tdo}, {3'h0, i[0]});
      #23;
    end
    usb_s = 3'h3;
    repeat (8) @(negedge sys_clk_i);
    check("link_on", {3'h0, lact}, 4'h1);
    repeat (40) @(negedge sys_clk_i);
    check("link_off", {3'h0, lact}, 4'h0);
  endtask : link_frame

  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_count++;
      end_sim();
    end
  end

  initial
  begin
    rst_b_i = 1'h0;
    cab = 1'h0;
    usb = 1'h0;
    ext_s = 3'h3;
    usb_s = 3'h3;
    fab_s = 3'h3;
    repeat (6) @(negedge sys_clk_i);
    check("rst_out", {src, lact, tck}, 4'h0);
    check("rst_tdo", {1'h0, ext_tdo, usb_tdo, fab_tdo}, 4'h7);
    rst_b_i = 1'h1;
    to_src(jsp_pkg::JSP_SRC_FAB);
    route(jsp_pkg::JSP_SRC_FAB);
    usb = 1'h1;
    to_src(jsp_pkg::JSP_SRC_USB);
    route(jsp_pkg::JSP_SRC_USB);
    link_frame();
    cab = 1'h1;
    to_src(jsp_pkg::JSP_SRC_EXT);
    usb = 1'h0;
    repeat (12) @(negedge sys_clk_i);
    check("ext_hold", {2'h0, src}, 4'h2);
    route(jsp_pkg::JSP_SRC_EXT);
    usb = 1'h1;
    cab = 1'h0;
    to_src(jsp_pkg::JSP_SRC_USB);
    usb = 1'h0;
    to_src(jsp_pkg::JSP_SRC_FAB);
    cab = 1'h1;
    to_src(jsp_pkg::JSP_SRC_EXT);
    route(jsp_pkg::JSP_SRC_EXT);
    end_sim();
  end
endmodule : jsp_jtag_select_tb_top
